// ### hdl/pdc_cal_seq.v
// Calibration sequencer for the first synthesizer
`timescale 1ns/1ps
`default_nettype none

module pdc_cal_seq #(
  parameter CAL_CYCLES = 50,
  parameter CNT_W = 16
) (
  input wire clock,
  input wire sys_rst,
  input wire power_down,
  output reg synth_enable_q,
  output reg cal_busy_q,
  output reg cal_done_q,
  output reg cal_reset_q
);

  localparam ST_OFF = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_RUN = 2'h2;
  // Last count of the calibration, cut to the counter width on purpose
  localparam [31:0] CAL_LAST32 = CAL_CYCLES - 1;
  localparam [CNT_W-1:0] CAL_LAST = CAL_LAST32[CNT_W-1:0];

  reg [1:0] state_q;
  reg [CNT_W-1:0] cnt_q;

  // ========================================================================
  // Sequencer: reset starts a calibration; power-down aborts and clears it
  always @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_OFF;
      cnt_q <= {CNT_W{1'b0}};
      synth_enable_q <= 1'b0;
      cal_busy_q <= 1'b0;
      cal_done_q <= 1'b0;
      cal_reset_q <= 1'b1;
    end else begin
      case (state_q)
        ST_OFF: begin
          cnt_q <= {CNT_W{1'b0}};
          cal_done_q <= 1'b0;
          if (!power_down) begin // RULE5 RULE7
            state_q <= ST_CAL;
            synth_enable_q <= 1'b1;
            cal_busy_q <= 1'b1;
            cal_reset_q <= 1'b0;
          end else begin
            synth_enable_q <= 1'b0;
            cal_busy_q <= 1'b0;
            cal_reset_q <= 1'b1;
          end
        end
        ST_CAL: begin
          if (power_down) begin // RULE6
            state_q <= ST_OFF;
            synth_enable_q <= 1'b0;
            cal_busy_q <= 1'b0;
            cal_reset_q <= 1'b1;
          end else if (cnt_q == CAL_LAST) begin
            state_q <= ST_RUN;
            cal_busy_q <= 1'b0;
            cal_done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RUN: begin
          if (power_down) begin // RULE6
            state_q <= ST_OFF;
            synth_enable_q <= 1'b0;
            cal_done_q <= 1'b0;
            cal_reset_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

endmodule // pdc_cal_seq

`default_nettype wire

// ### hdl/pdc_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef PDC_REGS_VH
`define PDC_REGS_VH

// ==========================================================================
// Register offsets (byte addresses on the host port)
`define PDC_ADDR_W 8
`define PDC_OFS_B_REF_DIV 8'h36
`define PDC_OFS_B_M_DIV 8'h37
`define PDC_OFS_A_CTRL0 8'h38
`define PDC_OFS_A_STATUS 8'h39

// ==========================================================================
// Field positions and widths
`define PDC_REF_DIV_W 3
`define PDC_M_DIV_W 5
`define PDC_POST_SEL_LSB 2
`define PDC_POST_SEL_MSB 4
`define PDC_RESYNC_BIT 1
`define PDC_PDN_BIT 0

// ==========================================================================
// Reset values
`define PDC_RST_REF_DIV 3'h0
`define PDC_RST_M_DIV 5'h00
`define PDC_RST_POST_SEL 3'h7
`define PDC_RST_RESYNC 1'b1
`define PDC_RST_PDN 1'b0

// ==========================================================================
// Calibration timing
`define PDC_CAL_TIME_NS 1000
`define PDC_CLK_PERIOD_NS 20
`define PDC_CAL_CYCLES (`PDC_CAL_TIME_NS / `PDC_CLK_PERIOD_NS)

`endif

// ### hdl/pdc_top.v
// Divider and control registers for the two frequency synthesizers
// Functional notes
// RULE1: Reference divider code zero bypasses, else k+1
// RULE2: M divider code zero bypasses, else k+1
// RULE3: Post divider codes 0,1 give two; reset 7
// RULE4: Resync enable lets sync realign channels; reset 1
// RULE5: After reset, enable and calibrate if not down
// RULE6: Power-down set disables synthesizer, resets calibration
// RULE7: Power-down cleared re-enables and recalibrates automatically
// RULE8: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.vh"

module pdc_top #(
  parameter CAL_CYCLES = `PDC_CAL_CYCLES
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire sync_in,
  output reg [7:0] reg_rdata_q,
  output reg [3:0] synth_b_ref_ratio_q,
  output reg [5:0] synth_b_m_ratio_q,
  output reg synth_b_ref_bypass_q,
  output reg synth_b_m_bypass_q,
  output reg [3:0] synth_a_post_ratio_q,
  output reg synth_a_resync_q,
  output wire synth_a_enable_q,
  output wire synth_a_cal_busy_q,
  output wire synth_a_cal_reset_q
);

  // ========================================================================
  // Field storage
  reg [2:0] synth_b_ref_div_code_q;
  reg [4:0] synth_b_m_div_code_q;
  reg [2:0] synth_a_post_div_sel_q;
  reg synth_a_resync_enable_q;
  reg synth_a_power_down_q;
  reg [2:0] sync_sr_q;
  reg sync_lvl_q;
  wire cal_done;

  // Post-divider ratio: the two lowest codes both mean divide by two
  function [3:0] post_ratio;
    input [2:0] sel;
    begin
      if (sel < 3'h2)
        post_ratio = 4'h2; // RULE3
      else
        post_ratio = {1'b0, sel} + 4'h1; // RULE3
    end
  endfunction

  // ========================================================================
  // Register writes; only defined field bits are stored
  always @(posedge clock) begin
    if (sys_rst) begin
      synth_b_ref_div_code_q <= `PDC_RST_REF_DIV;
      synth_b_m_div_code_q <= `PDC_RST_M_DIV;
      synth_a_post_div_sel_q <= `PDC_RST_POST_SEL; // RULE3
      synth_a_resync_enable_q <= `PDC_RST_RESYNC; // RULE4
      synth_a_power_down_q <= `PDC_RST_PDN; // RULE5
    end else if (reg_wr) begin
      case (reg_addr)
        `PDC_OFS_B_REF_DIV: begin
          synth_b_ref_div_code_q <= reg_wdata[`PDC_REF_DIV_W-1:0]; // RULE8
        end
        `PDC_OFS_B_M_DIV: begin
          synth_b_m_div_code_q <= reg_wdata[`PDC_M_DIV_W-1:0]; // RULE8
        end
        `PDC_OFS_A_CTRL0: begin
          synth_a_post_div_sel_q <=
            reg_wdata[`PDC_POST_SEL_MSB:`PDC_POST_SEL_LSB];
          synth_a_resync_enable_q <= reg_wdata[`PDC_RESYNC_BIT];
          synth_a_power_down_q <= reg_wdata[`PDC_PDN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Read data one cycle after the strobe, zero otherwise and when unmapped
  always @(posedge clock) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        `PDC_OFS_B_REF_DIV: reg_rdata_q <= {5'h00, synth_b_ref_div_code_q};
        `PDC_OFS_B_M_DIV: reg_rdata_q <= {3'h0, synth_b_m_div_code_q};
        `PDC_OFS_A_CTRL0: reg_rdata_q <= {3'h0, synth_a_post_div_sel_q,
          synth_a_resync_enable_q, synth_a_power_down_q}; // RULE8
        `PDC_OFS_A_STATUS: reg_rdata_q <= {5'h00, cal_done,
          synth_a_cal_busy_q, synth_a_enable_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ========================================================================
  // Divider ratios decoded for the synthesizers
  always @(posedge clock) begin
    if (sys_rst) begin
      synth_b_ref_ratio_q <= 4'h1;
      synth_b_m_ratio_q <= 6'h01;
      synth_b_ref_bypass_q <= 1'b1;
      synth_b_m_bypass_q <= 1'b1;
      synth_a_post_ratio_q <= 4'h8;
    end else begin
      synth_b_ref_bypass_q <= (synth_b_ref_div_code_q == 3'h0); // RULE1
      synth_b_ref_ratio_q <= {1'b0, synth_b_ref_div_code_q} + 4'h1; // RULE1
      synth_b_m_bypass_q <= (synth_b_m_div_code_q == 5'h00); // RULE2
      synth_b_m_ratio_q <= {1'b0, synth_b_m_div_code_q} + 6'h01; // RULE2
      synth_a_post_ratio_q <= post_ratio(synth_a_post_div_sel_q);
    end
  end

  // ========================================================================
  // Sync pin: three stages, a rising change counts once stages 2 and 3 agree
  always @(posedge clock) begin
    if (sys_rst) begin
      sync_sr_q <= 3'h0;
      sync_lvl_q <= 1'b0;
      synth_a_resync_q <= 1'b0;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], sync_in};
      if (sync_sr_q[1] == sync_sr_q[2])
        sync_lvl_q <= sync_sr_q[2];
      // Powered-down synthesizer has no channels to realign
      synth_a_resync_q <= synth_a_resync_enable_q && synth_a_enable_q &&
        (sync_sr_q[1] == sync_sr_q[2]) && sync_sr_q[2] && !sync_lvl_q; // RULE4
    end
  end

  // ========================================================================
  // Power and calibration sequencing
  pdc_cal_seq #(
    .CAL_CYCLES(CAL_CYCLES),
    .CNT_W(16)
  ) u_cal (
    .clock(clock),
    .sys_rst(sys_rst),
    .power_down(synth_a_power_down_q), // RULE5 RULE6 RULE7
    .synth_enable_q(synth_a_enable_q),
    .cal_busy_q(synth_a_cal_busy_q),
    .cal_done_q(cal_done),
    .cal_reset_q(synth_a_cal_reset_q)
  );

endmodule // pdc_top

`default_nettype wire

// ### tb/pdc_props.sv
// Checker for the synthesizer divider and control registers
`timescale 1ns/1ps
`default_nettype none
module pdc_props #(
  parameter CAL_CYCLES = 4
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire [3:0] synth_b_ref_ratio_q,
  input wire [5:0] synth_b_m_ratio_q,
  input wire synth_b_ref_bypass_q,
  input wire synth_b_m_bypass_q,
  input wire [3:0] synth_a_post_ratio_q,
  input wire synth_a_resync_q,
  input wire synth_a_enable_q,
  input wire synth_a_cal_busy_q,
  input wire synth_a_cal_reset_q
);
  // Reset masks everything; outputs are checked only in normal running
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Divider outputs and register space
  a_ref_map: assert property (synth_b_ref_bypass_q ==
    (synth_b_ref_ratio_q == 4'h1)) else $error("ref bypass wrong");
  a_m_map: assert property (synth_b_m_bypass_q ==
    (synth_b_m_ratio_q == 6'h01)) else $error("m bypass wrong");
  a_post_range: assert property (synth_a_post_ratio_q >= 4'h2 &&
    synth_a_post_ratio_q <= 4'h8) else $error("post ratio range");
  a_ref_rsvd: assert property ($past(reg_rd && reg_addr == 8'h36)
    |-> reg_rdata_q[7:3] == 5'h00) else $error("reserved bits set");
  // ==========================================================
  // Power-down, calibration and resync
  a_reset_cal: assert property ($past(sys_rst) |-> ##[0:1]
    (synth_a_enable_q && synth_a_cal_busy_q)) else $error("no cal");
  a_pdn_off: assert property (reg_wr && reg_addr == 8'h38 &&
    reg_wdata[0] |-> ##2 !synth_a_enable_q && synth_a_cal_reset_q)
    else $error("power-down ignored");
  a_pdn_recal: assert property (reg_wr && reg_addr == 8'h38 &&
    !reg_wdata[0] && !synth_a_enable_q |-> ##2 synth_a_enable_q &&
    synth_a_cal_busy_q) else $error("no recalibration");
  a_resync_pulse: assert property (synth_a_resync_q |->
    synth_a_enable_q ##1 !synth_a_resync_q) else $error("bad resync");
endmodule // pdc_props
bind pdc_top pdc_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
  .clock(clock),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .synth_b_ref_ratio_q(synth_b_ref_ratio_q),
  .synth_b_m_ratio_q(synth_b_m_ratio_q),
  .synth_b_ref_bypass_q(synth_b_ref_bypass_q),
  .synth_b_m_bypass_q(synth_b_m_bypass_q),
  .synth_a_post_ratio_q(synth_a_post_ratio_q),
  .synth_a_resync_q(synth_a_resync_q),
  .synth_a_enable_q(synth_a_enable_q),
  .synth_a_cal_busy_q(synth_a_cal_busy_q),
  .synth_a_cal_reset_q(synth_a_cal_reset_q)
);
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the synthesizer divider and control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Clock, reset and host port
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg sync_in = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata_q;
  wire [3:0] synth_b_ref_ratio_q, synth_a_post_ratio_q;
  wire [5:0] synth_b_m_ratio_q;
  wire synth_b_ref_bypass_q, synth_b_m_bypass_q, synth_a_resync_q;
  wire synth_a_enable_q, synth_a_cal_busy_q, synth_a_cal_reset_q;
  integer miscompares = 0;
  integer n_compared = 0;
  integer i, n;
  // Bypass flag and ratio side by side, as one compare
  wire [4:0] ref_obs = {synth_b_ref_bypass_q, synth_b_ref_ratio_q};
  wire [6:0] m_obs = {synth_b_m_bypass_q, synth_b_m_ratio_q};
  always #10 clock = ~clock;
  // Short calibration keeps the run brief
  pdc_top #(.CAL_CYCLES(4)) uut (
    .clock(clock),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .sync_in(sync_in),
    .reg_rdata_q(reg_rdata_q),
    .synth_b_ref_ratio_q(synth_b_ref_ratio_q),
    .synth_b_m_ratio_q(synth_b_m_ratio_q),
    .synth_b_ref_bypass_q(synth_b_ref_bypass_q),
    .synth_b_m_bypass_q(synth_b_m_bypass_q),
    .synth_a_post_ratio_q(synth_a_post_ratio_q),
    .synth_a_resync_q(synth_a_resync_q),
    .synth_a_enable_q(synth_a_enable_q),
    .synth_a_cal_busy_q(synth_a_cal_busy_q),
    .synth_a_cal_reset_q(synth_a_cal_reset_q)
  );
  // ==========================================================
  // Tasks
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task tk(input integer k);
    begin
      repeat (k) @(posedge clock);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, e);
    end
  endtask
  task finish_test;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ==========================================================
  // Main sequence; reserved bits are written as ones in the divider sweeps
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    tk(2);
    chk({synth_a_enable_q, synth_a_cal_busy_q}, 2'b11);
    rd(8'h38, 8'h1e);
    rd(8'h37, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h36, 8'hf8 | i[7:0]);
      tk(2);
      chk(ref_obs, {i == 0, i[3:0] + 4'h1});
      rd(8'h36, i[7:0]);
      wr(8'h38, {3'h7, i[2:0], 2'h2});
      tk(2);
      chk(synth_a_post_ratio_q, i < 2 ? 2 : i + 1);
      rd(8'h38, {3'h0, i[2:0], 2'h2});
    end
    for (i = 0; i < 32; i = i + 1) begin
      wr(8'h37, 8'he0 | i[7:0]);
      tk(2);
      chk(m_obs, {i == 0, i[5:0] + 6'h01});
      rd(8'h37, i[7:0]);
    end
    wr(8'h38, 8'h1f);
    tk(2);
    chk({synth_a_enable_q, synth_a_cal_reset_q}, 2'b01);
    rd(8'h39, 8'h00);
    wr(8'h38, 8'h1e);
    tk(2);
    chk({synth_a_enable_q, synth_a_cal_busy_q}, 2'b11);
    n = 0;
    while (synth_a_cal_busy_q !== 1'b0 && n < 20) begin
      tk(1);
      n = n + 1;
    end
    chk(n < 20, 1);
    rd(8'h39, 8'h05);
    // Second pass has resync disabled and must see no pulse
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h38, i ? 8'h1c : 8'h1e);
      @(posedge clock) sync_in <= 1'b1;
      n = 0;
      repeat (12) begin
        tk(1);
        n = n + (synth_a_resync_q === 1'b1);
      end
      sync_in <= 1'b0;
      chk(n, i ? 0 : 1);
    end
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
